// ---- dv/dls_conv_model.sv ----
// converter model that answers only the latest start pulse after a fixed latency
`timescale 1ns/10ps
`default_nettype none
module dls_conv_model #(
  parameter int LAT = 3 // cycles from start to result
) (
  input wire logic mclk, // clock
  input wire logic conv_start, // start pulse
  input wire logic [3:0] conv_chan, // channel to convert
  output logic adc_done, // result pulse
  output logic [11:0] adc_data // result, scrambled outside the pulse
);
  int cnt = 0;
  logic done_q = 1'b0;
  logic [3:0] ch_q = 4'h0;
  always_ff @(posedge mclk) begin
    done_q <= (cnt == 1) && !conv_start;
    if (conv_start) begin
      cnt <= LAT;
      ch_q <= conv_chan;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  assign adc_done = done_q;
  // inverted data between pulses so a late sample never matches by luck
  assign adc_data = done_q ? {ch_q, 8'ha5} : ~{ch_q, 8'ha5};
endmodule : dls_conv_model
`default_nettype wire

// ---- dv/dls_ctrl_tb_top.sv ----
// self-checking bench for the load mode and sequencing control
`timescale 1ns/10ps
`default_nettype none
module dls_ctrl_tb_top;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic ptr_we = 1'b0;
  logic [7:0] ptr_byte = 8'h00;
  logic data_we = 1'b0;
  logic [15:0] data_word = 16'h0000;
  logic msb_ack = 1'b0;
  logic adc_done;
  logic [11:0] adc_data;
  logic [7:0][11:0] dac_out;
  logic dac_load;
  logic [1:0] load_transfer_mode;
  logic [15:0] rd_word;
  logic conv_start;
  logic [3:0] conv_chan;
  logic seq_live;
  int n_fail = 0;
  int total_checks = 0;
  logic load_seen = 1'b0;
  dls_ctrl dut_u (.mclk(mclk), .nrst(nrst), .ptr_we(ptr_we), .ptr_byte(ptr_byte),
    .data_we(data_we), .data_word(data_word), .msb_ack(msb_ack), .adc_done(adc_done),
    .adc_data(adc_data), .dac_out(dac_out), .dac_load(dac_load),
    .load_transfer_mode(load_transfer_mode),
    .rd_word(rd_word), .conv_start(conv_start), .conv_chan(conv_chan), .seq_live(seq_live));
  dls_conv_model conv_u (.mclk(mclk), .conv_start(conv_start), .conv_chan(conv_chan),
    .adc_done(adc_done), .adc_data(adc_data));
  initial begin
    forever #2 mclk = ~mclk;
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : complete_run
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // pointer byte, then a data word when has_data is set
  task automatic wr(input logic [7:0] p, input logic [15:0] d, input bit has_data);
    @(posedge mclk);
    ptr_we <= 1'b1;
    ptr_byte <= p;
    @(posedge mclk);
    ptr_we <= 1'b0;
    data_we <= has_data;
    data_word <= d;
    @(posedge mclk);
    data_we <= 1'b0;
    // the load pulse stands only for the cycle after the data edge
    #1;
    load_seen = dac_load;
    @(posedge mclk);
    #1;
  endtask : wr
  // one read word; conv waits for the converter and checks that the start pulse was seen
  task automatic rd(input logic [15:0] exp, input bit conv);
    bit seen;
    int i;
    seen = 0;
    @(posedge mclk);
    msb_ack <= 1'b1;
    @(posedge mclk);
    msb_ack <= 1'b0;
    for (i = 0; i < 40 && conv && !adc_done; i++) begin
      @(posedge mclk);
      if (conv_start) seen = 1;
    end
    if (i == 40) begin
      n_fail++;
      $display("CHECK FAILED adc_done expected 1 seen 0");
      complete_run();
    end
    if (conv) chk("conv_start", 16'h1, 16'(seen));
    @(posedge mclk);
    #1;
    chk("rd_word", exp, rd_word);
  endtask : rd
  function automatic logic [15:0] aw(input logic [3:0] ch);
    return {1'b0, ch[2:0], ch, 8'ha5};
  endfunction : aw
  initial begin
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    #1;
    chk("mode", 16'h0, 16'(load_transfer_mode));
    chk("seq_live", 16'h0, 16'(seq_live));
    wr(8'h12, 16'h0abc, 1);
    chk("dac2", 16'h0abc, 16'(dac_out[2]));
    chk("dac_load", 16'h1, 16'(load_seen));
    wr(8'h07, 16'h0001, 1);
    wr(8'h13, 16'h0123, 1);
    chk("dac3", 16'h0, 16'(dac_out[3]));
    chk("dac_load", 16'h0, 16'(load_seen));
    chk("mode", 16'h1, 16'(load_transfer_mode));
    wr(8'h53, 16'h0000, 0);
    rd(16'hb123, 0);
    wr(8'h07, 16'h0003, 1);
    wr(8'h14, 16'h0444, 1);
    chk("dac4", 16'h0, 16'(dac_out[4]));
    chk("dac_load", 16'h0, 16'(load_seen));
    wr(8'h07, 16'h0002, 1);
    chk("dac3", 16'h0123, 16'(dac_out[3]));
    chk("dac_load", 16'h1, 16'(load_seen));
    chk("dac4", 16'h0444, 16'(dac_out[4]));
    chk("mode", 16'h1, 16'(load_transfer_mode));
    wr(8'h02, 16'h0281, 1);
    chk("conv_chan", 16'h0, 16'(conv_chan));
    wr(8'h40, 16'h0000, 0);
    rd(aw(4'h0), 1);
    rd(aw(4'h7), 1);
    rd(aw(4'h0), 1);
    wr(8'h02, 16'h0101, 1);
    wr(8'h40, 16'h0000, 0);
    rd(aw(4'h0), 1);
    rd(aw(4'h8), 1);
    chk("seq_live", 16'h0, 16'(seq_live));
    rd(aw(4'h8), 0);
    wr(8'h02, 16'h0003, 1);
    wr(8'h40, 16'h0000, 0);
    rd(aw(4'h0), 1);
    wr(8'h02, 16'h0084, 1);
    chk("conv_chan", 16'h2, 16'(conv_chan));
    wr(8'h40, 16'h0000, 0);
    rd(aw(4'h2), 1);
    wr(8'h02, 16'h0000, 1);
    chk("seq_live", 16'h0, 16'(seq_live));
    // a mid-run reset must bring back the immediate load mode
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (4) @(posedge mclk);
    nrst <= 1'b1;
    #1;
    chk("mode", 16'h0, 16'(load_transfer_mode));
    wr(8'h15, 16'h0555, 1);
    chk("dac5", 16'h0555, 16'(dac_out[5]));
    chk("dac_load", 16'h1, 16'(load_seen));
    complete_run();
  end
endmodule : dls_ctrl_tb_top
`default_nettype wire

// ---- hw/dls_ctrl.sv ----
// dac load modes, dac readback and adc channel sequencing
`timescale 1ns/10ps
`default_nettype none
module dls_ctrl (
  input wire logic mclk, // 250 MHz clock
  input wire logic nrst, // sync reset, low
  input wire logic ptr_we, // pointer byte taken
  input wire logic [7:0] ptr_byte, // pointer byte
  input wire logic data_we, // data word taken
  input wire logic [15:0] data_word, // data word
  input wire logic msb_ack, // scl rise at ack before msb
  input wire logic adc_done, // converter finished
  input wire logic [11:0] adc_data, // converter result
  output logic [7:0][11:0] dac_out, // dac registers
  output logic dac_load, // dac registers changed
  output logic [1:0] load_transfer_mode, // load mode
  output logic [15:0] rd_word, // word to shift out
  output logic conv_start, // start conversion
  output logic [3:0] conv_chan, // tracked channel, 8 temp
  output logic seq_live // channels pending
);
  import dls_pkg::*;

  dls_state_t s_q;
  dls_state_t s_d;

  // lowest selected channel at or above start, descending scan, last match wins
  function automatic logic [4:0] first_ch(
    input logic [NCH-1:0] mask,
    input logic [3:0] start
  );
    logic [4:0] r;
    r = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (mask[i] && (4'(i) >= start)) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction : first_ch

  // pointer mode nibble decode, shared by the datapath and the checks
  function automatic logic ptr_dac_wr(input logic [7:0] p);
    return p[7:4] == PM_DACWR;
  endfunction : ptr_dac_wr

  function automatic logic ptr_dac_rd(input logic [7:0] p);
    return p[7:4] == PM_DACRD;
  endfunction : ptr_dac_rd

  logic [4:0] nxt;
  logic [4:0] wrap;
  logic [4:0] fst;
  logic [2:0] widx;

  // chan tops out at 8, so the step never wraps four bits
  assign nxt = first_ch(s_q.seq[NCH-1:0], 4'(s_q.chan + CH_STEP));
  assign wrap = first_ch(s_q.seq[NCH-1:0], '0);
  assign fst = first_ch(data_word[NCH-1:0], '0);
  assign widx = s_q.ptr[2:0];

  always_comb begin
    s_d = s_q;
    s_d.dac_load = 1'b0;
    s_d.conv_start = 1'b0;
    if (ptr_we) begin
      s_d.ptr = ptr_byte;
    end
    // result tagged and channel advanced when the converter answers
    if (s_q.st == ST_CONV && adc_done) begin
      s_d.st = ST_IDLE;
      s_d.rd_word = {TAG_ADC, s_q.chan[2:0], adc_data};
      if (nxt[4]) begin
        s_d.chan = nxt[3:0];
      end else if (s_q.seq[REP_BIT] && wrap[4]) begin
        s_d.chan = wrap[3:0];
      end else begin
        s_d.live = 1'b0;
      end
    end
    if (msb_ack) begin
      if (ptr_dac_rd(s_q.ptr)) begin
        s_d.rd_word = {TAG_DAC, widx, s_q.inreg[widx]};
      end else if (s_q.ptr == PTR_ADCRD && s_q.st == ST_IDLE
                   && s_q.live) begin
        s_d.conv_start = 1'b1;
        s_d.st = ST_CONV;
      end
    end
    if (data_we) begin
      if (ptr_dac_wr(s_q.ptr)) begin
        s_d.inreg[widx] = data_word[11:0];
        if (s_q.mode == LM_AUTO) begin
          s_d.dacr[widx] = data_word[11:0];
          s_d.dac_load = 1'b1;
        end
        // hold and reserved modes leave dac registers alone
      end else if (s_q.ptr == PTR_LDM) begin
        if (data_word[1:0] == LM_SIM) begin
          s_d.dacr = s_q.inreg;
          s_d.dac_load = 1'b1;
          s_d.mode = LM_HOLD;
        end else begin
          s_d.mode = data_word[1:0];
        end
      end else if (s_q.ptr == PTR_SEQ) begin
        // a write mid-conversion still restarts; the late result is dropped
        s_d.seq = data_word[SEQ_W-1:0];
        s_d.chan = fst[3:0];
        s_d.live = fst[4];
        s_d.st = ST_IDLE;
        // a start raised in this same cycle would run the converter for nothing
        s_d.conv_start = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dac_out = s_q.dacr;
  assign dac_load = s_q.dac_load;
  assign load_transfer_mode = s_q.mode;
  assign rd_word = s_q.rd_word;
  assign conv_start = s_q.conv_start;
  assign conv_chan = s_q.chan;
  assign seq_live = s_q.live;

  default clocking @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  logic ldm_wr;
  logic dac_wr;
  assign ldm_wr = data_we && s_q.ptr == PTR_LDM;
  assign dac_wr = data_we && ptr_dac_wr(s_q.ptr);

  property p_sim_load;
    ldm_wr && data_word[1:0] == LM_SIM
      |=> load_transfer_mode == LM_HOLD && dac_out == $past(s_q.inreg)
          && dac_load;
  endproperty
  a_sim_load: assert property (p_sim_load)
    else $error("simultaneous load failed");

  property p_mode_set;
    ldm_wr && data_word[1:0] != LM_SIM
      |=> load_transfer_mode == $past(data_word[1:0]);
  endproperty
  a_mode_set: assert property (p_mode_set)
    else $error("load mode not stored");

  property p_auto;
    dac_wr && s_q.mode == LM_AUTO
      |=> dac_load && dac_out[$past(widx)] == $past(data_word[11:0]);
  endproperty
  a_auto: assert property (p_auto)
    else $error("immediate mode did not update dac");

  property p_hold;
    dac_wr && s_q.mode == LM_HOLD |=> $stable(dac_out) && !dac_load;
  endproperty
  a_hold: assert property (p_hold)
    else $error("hold mode changed dac");

  property p_rsvd;
    dac_wr && s_q.mode == 2'h3 |=> $stable(dac_out);
  endproperty
  a_rsvd: assert property (p_rsvd)
    else $error("reserved mode changed dac");

  property p_dac_rd;
    msb_ack && ptr_dac_rd(s_q.ptr)
      |=> rd_word[15] == TAG_DAC && rd_word[14:12] == $past(widx)
          && rd_word[11:0] == $past(s_q.inreg[widx]);
  endproperty
  a_dac_rd: assert property (p_dac_rd)
    else $error("dac readback word wrong");

  property p_start;
    msb_ack && s_q.ptr == PTR_ADCRD && s_q.st == ST_IDLE && seq_live
      && !data_we |=> conv_start ##1 !conv_start;
  endproperty
  a_start: assert property (p_start)
    else $error("conversion not started at ack");

  property p_adc_word;
    s_q.st == ST_CONV && adc_done && !data_we
      |=> rd_word[15] == TAG_ADC && rd_word[14:12] == $past(conv_chan[2:0])
          && rd_word[11:0] == $past(adc_data);
  endproperty
  a_adc_word: assert property (p_adc_word)
    else $error("adc result word wrong");

  property p_ascend;
    s_q.st == ST_CONV && adc_done && !data_we && nxt[4]
      |=> conv_chan > $past(conv_chan);
  endproperty
  a_ascend: assert property (p_ascend)
    else $error("channel order not ascending");

  property p_last;
    !seq_live && !data_we |=> $stable(rd_word) || $past(msb_ack)
      ##0 !conv_start;
  endproperty
  a_last: assert property (p_last)
    else $error("conversion after sequence end");

  property p_new_seq;
    data_we && s_q.ptr == PTR_SEQ
      |=> conv_chan == $past(fst[3:0]) && seq_live == $past(fst[4]);
  endproperty
  a_new_seq: assert property (p_new_seq)
    else $error("new sequence not restarted");

  property p_mode_hold;
    !ldm_wr |=> $stable(load_transfer_mode);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("load mode changed without a write");

  property p_dac_hold;
    !dac_wr && !ldm_wr |=> $stable(dac_out) && !dac_load;
  endproperty
  a_dac_hold: assert property (p_dac_hold)
    else $error("dac registers changed without a write");

  // dac writes in hold and reserved modes must never raise the load pulse
  property p_load_cause;
    dac_load |-> $past(dac_wr && s_q.mode == LM_AUTO)
      || $past(ldm_wr && data_word[1:0] == LM_SIM);
  endproperty
  a_load_cause: assert property (p_load_cause)
    else $error("dac load pulse without cause");

  property p_start_once;
    conv_start |=> !conv_start;
  endproperty
  a_start_once: assert property (p_start_once)
    else $error("conversion start longer than one cycle");

  property p_start_cause;
    conv_start |-> $past(msb_ack) && $past(s_q.ptr) == PTR_ADCRD;
  endproperty
  a_start_cause: assert property (p_start_cause)
    else $error("conversion started away from the ack");

  property p_chan_range;
    conv_chan <= LAST_CH;
  endproperty
  a_chan_range: assert property (p_chan_range)
    else $error("tracked channel out of range");

  // holds only while live; after the end the channel is stale on purpose
  property p_chan_sel;
    seq_live |-> s_q.seq[conv_chan];
  endproperty
  a_chan_sel: assert property (p_chan_sel)
    else $error("tracked channel not in the sequence");

  property p_wrap;
    s_q.st == ST_CONV && adc_done && !data_we && !nxt[4] && s_q.seq[REP_BIT]
      |=> seq_live && conv_chan <= $past(conv_chan);
  endproperty
  a_wrap: assert property (p_wrap)
    else $error("repeat did not wrap the sequence");

  property p_end;
    s_q.st == ST_CONV && adc_done && !data_we && !nxt[4] && !s_q.seq[REP_BIT]
      |=> !seq_live;
  endproperty
  a_end: assert property (p_end)
    else $error("sequence did not end after the last channel");

  property p_stop;
    data_we && s_q.ptr == PTR_SEQ && data_word[NCH-1:0] == '0 |=> !seq_live;
  endproperty
  a_stop: assert property (p_stop)
    else $error("empty sequence left channels pending");

  property p_seq_idle;
    data_we && s_q.ptr == PTR_SEQ |=> s_q.st == ST_IDLE && !conv_start;
  endproperty
  a_seq_idle: assert property (p_seq_idle)
    else $error("new sequence kept the old conversion");

  // the last result must stand for later reads once the sequence ends
  property p_rd_hold;
    !$stable(rd_word) |-> $past(msb_ack) || $past(adc_done);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read word changed without a transfer");

  c_sim: cover property (ldm_wr && data_word[1:0] == LM_SIM);
  c_conv: cover property (conv_start ##[1:20] s_q.st == ST_CONV && adc_done);
  c_wrap: cover property (s_q.st == ST_CONV && adc_done && !nxt[4]
                          && s_q.seq[REP_BIT]);
  c_rdbk: cover property (msb_ack && ptr_dac_rd(s_q.ptr));
  c_end: cover property (s_q.st == ST_CONV && adc_done && !nxt[4] && !s_q.seq[REP_BIT]);
endmodule : dls_ctrl
`default_nettype wire

// ---- hw/dls_pkg.sv ----
// constants and types for the dac load and adc sequence control block
// Function
// - two-bit load mode at pointer 0x07 bits 1:0
// - mode 00 copies each write to dac
// - mode 01 writes input registers only
// - mode 10 loads all, returns to 01
// - pointer nibble 0101 selects dac readback
// - dac word: 1, index, twelve-bit value
// - pointer nibble 0001 plus index writes dac
// - sequence write tracks first chosen channel
// - channels convert ascending, one per transfer
// - conversion starts at ack before msb
// - repeat restarts; else last result repeats
// - adc word: 0, channel, twelve-bit result
// - new sequence drops pending, starts first
// - bit 9 repeat, bit 8 temperature
// - bits 7:0 add channels, none default
// - repeat keeps cycling until host stop
package dls_pkg;
  localparam logic [7:0] PTR_LDM = 8'h07;
  localparam logic [7:0] PTR_SEQ = 8'h02;
  localparam logic [7:0] PTR_ADCRD = 8'h40;
  localparam logic [3:0] PM_DACWR = 4'h1;
  localparam logic [3:0] PM_DACRD = 4'h5;
  localparam logic [1:0] LM_AUTO = 2'h0;
  localparam logic [1:0] LM_HOLD = 2'h1;
  localparam logic [1:0] LM_SIM = 2'h2;
  localparam int NCH = 9;
  localparam logic [3:0] LAST_CH = 4'h8;
  localparam logic [3:0] CH_STEP = 4'h1;
  localparam int REP_BIT = 9;
  localparam int SEQ_W = 10;
  localparam logic TAG_DAC = 1'b1;
  localparam logic TAG_ADC = 1'b0;
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } dls_st_t;
  typedef struct packed {
    logic [7:0] ptr;
    logic [1:0] mode;
    logic [SEQ_W-1:0] seq;
    logic [7:0][11:0] inreg;
    logic [7:0][11:0] dacr;
    logic dac_load;
    logic [15:0] rd_word;
    logic conv_start;
    logic [3:0] chan;
    logic live;
    dls_st_t st;
  } dls_state_t;
endpackage : dls_pkg
